// *** csarb_pkg.sv ***
package csarb_pkg;
	localparam int  CLK_HZ        = 125_000_000;
	localparam int  REST_TIME_S   = 90;
	localparam longint REST_CYC   = longint'(REST_TIME_S) * longint'(CLK_HZ);
	localparam int  REST_BAND_DIV = 200; // 0.5 % of span
	localparam int  FULL_SCALE    = 1000; // 100.0 % in 0.1 % units
	localparam int  RAMP_SLOW_S   = 40;
	localparam int  RAMP_FAST_S   = 10;
	localparam int  RAMP_SLOW_CYC = RAMP_SLOW_S * (CLK_HZ / FULL_SCALE);
	localparam int  RAMP_FAST_CYC = RAMP_FAST_S * (CLK_HZ / FULL_SCALE);
	localparam logic signed [15:0] MAN_MAX      = 16'sh041a; // 105.0 %
	localparam logic signed [15:0] OFF_SETPOINT = -16'sh7d00; // -32000
	localparam logic [2:0] FAIL_CFG_IGNORE = 3'h6;
	localparam logic [1:0] OFF_SRC_IF   = 2'h0;
	localparam logic [1:0] OFF_SRC_PIN  = 2'h1;
	localparam logic [1:0] OFF_SRC_PERM = 2'h2;
	localparam logic [1:0] OFF_SRC_PINN = 2'h3;
	// register byte addresses
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_STAT   = 8'h04;
	localparam logic [7:0] ADR_ABSMAN = 8'h08;
	localparam logic [7:0] ADR_DIFF   = 8'h0c;
	localparam logic [7:0] ADR_STABLE = 8'h10;
	localparam logic [7:0] ADR_FALLBK = 8'h14;
	localparam logic [7:0] ADR_SUBST  = 8'h18;
	localparam logic [7:0] ADR_SETPT  = 8'h1c;
	localparam logic [7:0] ADR_SPAN   = 8'h20;
	localparam logic [7:0] ADR_FORCE  = 8'h24;
	localparam logic [7:0] ADR_OUT    = 8'h28;
	localparam logic [15:0] SPAN_RESET  = 16'h03e8;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam int FORCE_W = 3; // outputs 17 to 19

	typedef enum logic [2:0] {
		ST_AUTO  = 3'b000,
		ST_TRUN  = 3'b001,
		ST_TERR  = 3'b010,
		ST_SENS  = 3'b011,
		ST_MAN   = 3'b100,
		ST_TRACK = 3'b101,
		ST_OFF   = 3'b110
	} csarb_status_e;

	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_WAIT = 2'b01,
		T_RUN  = 2'b10,
		T_ERR  = 2'b11
	} csarb_tune_e;

	// control word, bit 0 is tuneCmd, bit 11 top of failCfg
	typedef struct packed {
		logic [2:0] failCfg;
		logic [1:0] offSrc;
		logic       stepping;
		logic       rampFast;
		logic       decReq;
		logic       incReq;
		logic       offReq;
		logic       manReq;
		logic       tuneCmd;
	} csarb_ctrl_s;

	// status word, bits 2:0 the encoded status
	typedef struct packed {
		logic          tuneErr;
		logic          atRest;
		logic          tuneRun;
		csarb_status_e st;
	} csarb_stat_s;

	localparam csarb_ctrl_s CTRL_RESET = 12'h000;
endpackage : csarb_pkg

// *** csarb_rest_detect.sv ***
`timescale 1ns/1ns
// watches the measured value for the process-at-rest condition
module csarb_rest_detect #(
	parameter longint REST_CYC = csarb_pkg::REST_CYC,
	parameter int     CW       = 40
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic signed [15:0] meas,
	input  wire logic [15:0]        span,
	output logic                    atRest
);
	import csarb_pkg::*;

	logic signed [15:0] refReg;
	logic [CW-1:0]      cntReg;
	logic signed [16:0] diff;
	logic [16:0]        mag;
	logic [24:0]        scaled;
	logic               inBand;

	if (REST_CYC < 1 || REST_CYC >= (longint'(1) << CW)) begin : g_bad
		$error("rest count does not fit the counter");
	end

	// band check without a divider: 200*|dx| <= span
	assign diff   = 17'(meas) - 17'(refReg);
	assign mag    = diff[16] ? 17'(-diff) : 17'(diff);
	assign scaled = 25'(mag) * 25'(REST_BAND_DIV);
	assign inBand = scaled <= 25'(span);

	// leaving the band restarts the time from the new value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refReg <= 16'sh0000;
			cntReg <= '0;
			atRest <= 1'b0;
		end else if (!inBand) begin
			refReg <= meas;
			cntReg <= '0;
			atRest <= 1'b0;
		end else begin
			if (cntReg != '1)
				cntReg <= cntReg + 1'b1;
			atRest <= 64'(cntReg) >= REST_CYC;
		end
	end
endmodule : csarb_rest_detect

// *** csarb_top.sv ***
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
// per-loop operating status arbiter with wishbone registers
module csarb_top #(
	parameter longint REST_CYC      = csarb_pkg::REST_CYC,
	parameter int     RAMP_SLOW_CYC = csarb_pkg::RAMP_SLOW_CYC,
	parameter int     RAMP_FAST_CYC = csarb_pkg::RAMP_FAST_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic signed [15:0]    measIn,
	input  wire logic signed [15:0]    ctrlValue,
	input  wire logic                  sensorFail,
	input  wire logic                  trackReq,
	input  wire logic signed [15:0]    trackValue,
	input  wire logic                  switch_off_control_pin,
	input  wire logic                  extOffVoltage,
	input  wire logic                  tuneDone,
	input  wire logic                  tuneFail,
	input  wire logic                  nvValid,
	input  wire csarb_pkg::csarb_ctrl_s nvCtrl,
	output logic signed [15:0]         corrOut,
	output csarb_pkg::csarb_stat_s     statusOut,
	output logic                       tune_running_flag,
	output logic signed [15:0]         ctrlMeas,
	output logic                       reinitPulse,
	output logic [2:0]                 forcedOut,
	output logic                       actUp,
	output logic                       actDown
);
	import csarb_pkg::*;

	if (RAMP_SLOW_CYC < 1 || RAMP_FAST_CYC < 1) begin : g_bad
		$error("ramp step counts must be at least one");
	end

	csarb_ctrl_s        ctrlReg;
	csarb_tune_e        tuneReg, tuneNext;
	csarb_status_e      stReg, stNext;
	logic signed [15:0] manReg, stableReg, fallbkReg, substReg;
	logic signed [15:0] spReg, holdReg, corrNext;
	logic [15:0]        spanReg, forceReg;
	logic [31:0]        rampCnt;
	logic               ackReg, pwrUpReg, atRest;
	logic               offCfg, offNow, sensNow, aboveTune, tuneClr;
	logic               busHit, wr, rampTick;
	logic [31:0]        wm;

	// byte-lane merge of a write into the old word
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = dat[8*i +: 8];
		return r;
	endfunction : wmerge

	// low half of a merged write, for the 16-bit value registers
	function automatic logic [15:0] wmerge16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = wmerge({16'h0000, old}, dat, sel);
		return r[15:0];
	endfunction : wmerge16

	// limit a wide sum to the manual output range
	function automatic logic signed [15:0] clampv(input logic signed [17:0] v);
		if (v > 18'(MAN_MAX))
			return MAN_MAX;
		else if (v < -18'(MAN_MAX))
			return -MAN_MAX;
		else
			return 16'(v);
	endfunction : clampv

	csarb_rest_detect #(
		.REST_CYC (REST_CYC),
		.CW       (40)
	) u_rest (
		.clk    (clk),
		.rst    (rst),
		.meas   (measIn),
		.span   (spanReg),
		.atRest (atRest)
	);

	// switch-off sources
	always_comb begin
		case (ctrlReg.offSrc)
			OFF_SRC_IF:   offCfg = ctrlReg.offReq;
			OFF_SRC_PIN:  offCfg = ctrlReg.offReq | switch_off_control_pin;
			OFF_SRC_PERM: offCfg = 1'b1;
			OFF_SRC_PINN: offCfg = ctrlReg.offReq | !switch_off_control_pin;
			default:      offCfg = ctrlReg.offReq;
		endcase
	end
	assign offNow    = offCfg | extOffVoltage | (spReg == OFF_SETPOINT);
	assign sensNow   = sensorFail && ctrlReg.failCfg != FAIL_CFG_IGNORE;
	assign aboveTune = offNow | trackReq | ctrlReg.manReq | sensNow;

	// fixed priority, highest first, every cycle
	always_comb begin
		if (offNow)
			stNext = ST_OFF;
		else if (trackReq)
			stNext = ST_TRACK;
		else if (ctrlReg.manReq)
			stNext = ST_MAN;
		else if (sensNow)
			stNext = ST_SENS;
		else if (tuneReg == T_ERR)
			stNext = ST_TERR;
		else if (tuneReg == T_WAIT || tuneReg == T_RUN)
			stNext = ST_TRUN;
		else
			stNext = ST_AUTO;
	end

	// tuning sequence; a refused or finished run clears the command
	always_comb begin
		tuneNext = tuneReg;
		tuneClr  = 1'b0;
		case (tuneReg)
			T_IDLE: begin
				if (ctrlReg.tuneCmd && aboveTune)
					tuneClr = 1'b1;
				else if (ctrlReg.tuneCmd)
					tuneNext = T_WAIT;
			end
			T_WAIT, T_RUN: begin
				if (aboveTune || !ctrlReg.tuneCmd) begin
					tuneNext = T_IDLE;
					tuneClr  = 1'b1;
				end else if (tuneFail) begin
					tuneNext = T_ERR;
				end else if (tuneReg == T_RUN && tuneDone) begin
					tuneNext = T_IDLE;
					tuneClr  = 1'b1;
				end else if (tuneReg == T_WAIT && atRest) begin
					tuneNext = T_RUN;
				end
			end
			T_ERR: begin
				if (!ctrlReg.tuneCmd)
					tuneNext = T_IDLE;
			end
			default: tuneNext = T_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tuneReg <= T_IDLE;
		else
			tuneReg <= tuneNext;
	end

	// waiting output chosen at the start edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			holdReg <= VALUE_RESET;
		else if (tuneReg == T_IDLE && tuneNext == T_WAIT)
			holdReg <= (stReg == ST_MAN) ? manReg : stableReg;
	end

	// correcting value for the winning status
	always_comb begin
		case (stNext)
			ST_AUTO:  corrNext = ctrlValue;
			ST_TRUN:  corrNext = (tuneReg == T_RUN) ? ctrlValue : holdReg;
			ST_TERR:  corrNext = stableReg;
			ST_SENS:  corrNext = fallbkReg;
			ST_MAN:   corrNext = manReg;
			ST_TRACK: corrNext = trackValue;
			ST_OFF:   corrNext = VALUE_RESET;
			default:  corrNext = VALUE_RESET;
		endcase
	end

	// status and driven outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stReg             <= ST_AUTO;
			corrOut           <= VALUE_RESET;
			tune_running_flag <= 1'b0;
			statusOut         <= '0;
			reinitPulse       <= 1'b0;
			forcedOut         <= 3'h0;
			actUp             <= 1'b0;
			actDown           <= 1'b0;
			ctrlMeas          <= VALUE_RESET;
		end else begin
			stReg             <= stNext;
			// a restored word is only seen one edge later, so hold zero meanwhile
			corrOut           <= (pwrUpReg && nvValid && stNext == ST_AUTO) ? VALUE_RESET : corrNext;
			tune_running_flag <= stNext == ST_TRUN;
			statusOut         <= {tuneNext == T_ERR, atRest, stNext == ST_TRUN, stNext};
			reinitPulse       <= stReg == ST_SENS && stNext != ST_SENS;
			forcedOut         <= (stNext == ST_OFF && ctrlReg.offSrc == OFF_SRC_PERM)
				? forceReg[FORCE_W-1:0] : 3'h0;
			actUp             <= stNext == ST_MAN && ctrlReg.stepping
				&& ctrlReg.incReq && !ctrlReg.decReq;
			actDown           <= stNext == ST_MAN && ctrlReg.stepping
				&& ctrlReg.decReq && !ctrlReg.incReq;
			ctrlMeas          <= (ctrlReg.failCfg == FAIL_CFG_IGNORE) ? substReg : measIn;
		end
	end

	// wishbone: ack one cycle after the request, write at the ack edge
	assign busHit = wb_cyc_i & wb_stb_i;
	assign wr     = busHit & wb_we_i & ackReg;
	assign wb_ack_o = ackReg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ackReg <= 1'b0;
		else
			ackReg <= busHit & !ackReg;
	end

	// unmapped addresses read zero and ignore writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (busHit && !ackReg) begin
			case (wb_adr_i)
				ADR_CTRL:   wb_dat_o <= {20'h00000, ctrlReg};
				ADR_STAT:   wb_dat_o <= {26'h0, statusOut};
				ADR_ABSMAN: wb_dat_o <= {16'h0000, manReg};
				ADR_STABLE: wb_dat_o <= {16'h0000, stableReg};
				ADR_FALLBK: wb_dat_o <= {16'h0000, fallbkReg};
				ADR_SUBST:  wb_dat_o <= {16'h0000, substReg};
				ADR_SETPT:  wb_dat_o <= {16'h0000, spReg};
				ADR_SPAN:   wb_dat_o <= {16'h0000, spanReg};
				ADR_FORCE:  wb_dat_o <= {16'h0000, forceReg};
				ADR_OUT:    wb_dat_o <= {16'h0000, corrOut};
				default:    wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	assign wm = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);

	// control word; a bus write in the same cycle beats the internal clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrlReg  <= CTRL_RESET;
			pwrUpReg <= 1'b1;
		end else begin
			pwrUpReg <= 1'b0;
			if (pwrUpReg && nvValid)
				ctrlReg <= nvCtrl;
			else if (wr && wb_adr_i == ADR_CTRL)
				ctrlReg <= 12'(wmerge({20'h00000, ctrlReg}, wb_dat_i, wb_sel_i));
			else if (tuneClr)
				ctrlReg.tuneCmd <= 1'b0;
		end
	end

	// plain value registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stableReg <= VALUE_RESET;
			fallbkReg <= VALUE_RESET;
			substReg  <= VALUE_RESET;
			spReg     <= VALUE_RESET;
			spanReg   <= SPAN_RESET;
			forceReg  <= 16'h0000;
		end else if (wr) begin
			case (wb_adr_i)
				ADR_STABLE: stableReg <= wmerge16(stableReg, wb_dat_i, wb_sel_i);
				ADR_FALLBK: fallbkReg <= wmerge16(fallbkReg, wb_dat_i, wb_sel_i);
				ADR_SUBST:  substReg  <= wmerge16(substReg, wb_dat_i, wb_sel_i);
				ADR_SETPT:  spReg     <= wmerge16(spReg, wb_dat_i, wb_sel_i);
				ADR_SPAN:   spanReg   <= wmerge16(spanReg, wb_dat_i, wb_sel_i);
				ADR_FORCE:  forceReg  <= {13'h0, wm[2:0]};
				default:    forceReg  <= forceReg;
			endcase
		end
	end

	// ramp pacing for increment and decrement
	assign rampTick = rampCnt >= 32'(ctrlReg.rampFast ? RAMP_FAST_CYC - 1 : RAMP_SLOW_CYC - 1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rampCnt <= 32'h0000_0000;
		else if (stNext != ST_MAN || ctrlReg.stepping || !(ctrlReg.incReq ^ ctrlReg.decReq) || rampTick)
			rampCnt <= 32'h0000_0000;
		else
			rampCnt <= rampCnt + 32'h0000_0001;
	end

	// manual value follows the output outside manual so the switch is bumpless;
	// adjustments only while manual, so error and off states refuse them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			manReg <= VALUE_RESET;
		end else if (pwrUpReg && nvValid) begin
			manReg <= VALUE_RESET;
		end else if (stNext != ST_MAN) begin
			manReg <= corrNext;
		end else if (wr && wb_adr_i == ADR_ABSMAN && !ctrlReg.stepping) begin
			manReg <= clampv(18'(signed'(wm[15:0])));
		end else if (wr && wb_adr_i == ADR_DIFF) begin
			manReg <= clampv(18'(manReg) + 18'(signed'(wm[15:0])));
		end else if (rampTick && !ctrlReg.stepping) begin
			manReg <= clampv(18'(manReg) + (ctrlReg.incReq ? 18'sh1 : -18'sh1));
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_off_wins: assert property (offNow |=> stReg == ST_OFF && corrOut == 16'sh0000)
		else $error("switch-off did not force zero output");
	a_sp_off: assert property (spReg == OFF_SETPOINT |=> stReg == ST_OFF)
		else $error("off set-point did not switch off");
	a_track_prio: assert property (!offNow && trackReq |=> stReg == ST_TRACK && corrOut == $past(trackValue))
		else $error("tracking not applied");
	a_tune_flag: assert property (tune_running_flag == (stReg == ST_TRUN))
		else $error("tuning flag disagrees with status");
	a_err_hold: assert property (stReg == ST_TERR |-> corrOut == $past(stableReg))
		else $error("tuning error output is not the stable value");
	a_err_ack: assert property (tuneReg == T_ERR && !ctrlReg.tuneCmd |=> tuneReg == T_IDLE)
		else $error("error not cleared by command");
	a_tune_abort: assert property ((tuneReg == T_WAIT || tuneReg == T_RUN) && aboveTune
		|=> tuneReg == T_IDLE ##1 stReg != ST_TRUN)
		else $error("tuning not aborted by higher status");
	a_done_auto: assert property (tuneReg == T_RUN && tuneDone && !tuneFail && !aboveTune
		&& ctrlReg.tuneCmd |=> tuneReg == T_IDLE)
		else $error("tuning completion not taken");
	a_sens_ignore: assert property (ctrlReg.failCfg == FAIL_CFG_IGNORE && !offNow && !trackReq
		|=> stReg != ST_SENS)
		else $error("sensor break entered while ignored");
	a_man_bump: assert property (stReg != ST_MAN ##1 stReg == ST_MAN |-> corrOut == $past(corrOut))
		else $error("manual entry was not bumpless");
	a_bus_ack: assert property (busHit && !ackReg |=> ackReg ##1 !ackReg)
		else $error("ack not a single cycle pulse");

	c_tune_done: cover property (tuneReg == T_RUN ##1 tuneReg == T_IDLE);
	c_tune_err: cover property (tuneReg == T_ERR);
	c_off: cover property (stReg == ST_OFF);
	c_manual: cover property (stReg == ST_MAN && rampTick);
endmodule : csarb_top

// *** csarb_wb_master.sv ***
`timescale 1ns/1ns
// fieldbus master side: one classic wishbone cycle at a time
module csarb_wb_master (
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] rdIn,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat
);
	// idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we  = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
	end

	// request held until ack is seen, released at that same edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdIn;
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a; // released lines do not keep the last value
		dat <= ~d;
	endtask : xfer
endmodule : csarb_wb_master

// *** test_controller_status_arbiter.sv ***
`timescale 1ns/1ns
module test_controller_status_arbiter;
	import csarb_pkg::*;
	localparam int RC = 40; // short rest time keeps the run brief
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              cyc, stb, we, ack;
	logic [7:0]        adr;
	logic [3:0]        sel;
	logic [31:0]       datW, datR, rdv, e, m;
	logic signed [15:0] measIn = 16'sh0, ctrlValue = 16'sh0, trackValue = 16'sh0, cv, tv;
	logic signed [15:0] corrOut, ctrlMeas;
	logic              sensorFail = 1'b0, trackReq = 1'b0, switch_off_control_pin = 1'b0;
	logic              extOffVoltage = 1'b0, tuneDone = 1'b0, tuneFail = 1'b0, nvValid = 1'b0;
	csarb_ctrl_s       nvCtrl = CTRL_RESET;
	csarb_stat_s       statusOut;
	logic              tune_running_flag, reinitPulse, actUp, actDown, off;
	logic [2:0]        forcedOut, ex;
	logic [31:0]       expQ[$], mskQ[$];
	int                errors = 0, checks_done = 0, seed = 32'haf32, n, b, d;

	always #4 clk = ~clk;

	csarb_top #(.REST_CYC(RC), .RAMP_SLOW_CYC(4), .RAMP_FAST_CYC(2)) DUT (.clk(clk), .rst(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
		.wb_dat_o(datR), .wb_ack_o(ack), .measIn(measIn), .ctrlValue(ctrlValue), .sensorFail(sensorFail),
		.trackReq(trackReq), .trackValue(trackValue), .switch_off_control_pin(switch_off_control_pin),
		.extOffVoltage(extOffVoltage), .tuneDone(tuneDone), .tuneFail(tuneFail), .nvValid(nvValid),
		.nvCtrl(nvCtrl), .corrOut(corrOut), .statusOut(statusOut), .tune_running_flag(tune_running_flag),
		.ctrlMeas(ctrlMeas), .reinitPulse(reinitPulse), .forcedOut(forcedOut), .actUp(actUp),
		.actDown(actDown));

	csarb_wb_master bus (.clk(clk), .ack(ack), .rdIn(datR), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(datW));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task nx(input int c);
		repeat (c) @(posedge clk);
	endtask : nx

	task wr(input logic [7:0] a, input logic [31:0] v);
		bus.xfer(1'b1, a, v, rdv);
	endtask : wr

	// the expectation is noted before the read goes out
	task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] k);
		expQ.push_back(v);
		mskQ.push_back(k);
		bus.xfer(1'b0, a, 32'h0, rdv);
	endtask : rd

	task st(input logic [2:0] s);
		rd(ADR_STAT, {29'h0, s}, 32'h7);
	endtask : st

	task ov(input logic signed [15:0] v);
		rd(ADR_OUT, {16'h0, v}, 32'hffff);
	endtask : ov

	task rv(output int v);
		bus.xfer(1'b0, ADR_OUT, 32'h0, rdv);
		v = int'($signed(rdv[15:0]));
	endtask : rv

	// read results are matched against the oldest note
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && expQ.size() > 0) begin
			e = expQ.pop_front();
			m = mskQ.pop_front();
			check(datR & m, e & m);
		end
	end

	// watchdog sized well above the expected run
	initial begin
		#400000;
		errors++;
		end_sim();
	end

	initial begin
		cv = 16'($random(seed) % 1000);
		tv = 16'($random(seed) % 1000);
		ctrlValue  <= cv;
		trackValue <= tv;
		measIn     <= 16'($random(seed) % 500);
		nx(12);
		rst <= 1'b0;
		rd(ADR_SPAN, 32'h3e8, 32'hffffffff);
		rd(ADR_CTRL, 32'h0, 32'hffffffff);
		rd(8'h30, 32'h0, 32'hffffffff);
		wr(ADR_FORCE, 32'hffff);
		rd(ADR_FORCE, 32'h7, 32'hffffffff);
		wr(ADR_FALLBK, 32'h0123);
		// every mix of sensor break, manual, track and off
		for (int i = 0; i < 16; i++) begin
			sensorFail <= i[0];
			trackReq   <= i[2];
			wr(ADR_CTRL, {29'h0, i[3], i[1], 1'b0});
			nx(2);
			ex = i[3] ? ST_OFF : i[2] ? ST_TRACK : i[1] ? ST_MAN : i[0] ? ST_SENS : ST_AUTO;
			st(ex);
			check(statusOut.st, ex);
			if (i[3]) ov(16'sh0);
			else if (i[2]) ov(tv);
			else if (!i[1]) ov(i[0] ? 16'sh0123 : cv);
		end
		trackReq <= 1'b0;
		wr(ADR_CTRL, 32'h0);
		nx(2);
		sensorFail <= 1'b0;
		n = 0;
		repeat (4) begin
			@(posedge clk);
			#1 n += (reinitPulse === 1'b1);
		end
		check(n, 1);
		// tuning from automatic, rest timer restarted by a jump
		wr(ADR_STABLE, 32'h00c8);
		measIn <= measIn + 16'sh0100;
		wr(ADR_CTRL, 32'h1);
		nx(2);
		st(ST_TRUN);
		ov(16'sh00c8);
		check(tune_running_flag, 32'h1);
		wr(ADR_SETPT, 32'h0150);
		rd(ADR_SETPT, 32'h0150, 32'hffff);
		nx(RC + 5);
		rd(ADR_STAT, 32'h11, 32'h17);
		ov(cv);
		tuneDone <= 1'b1;
		nx(1);
		tuneDone <= 1'b0;
		nx(2);
		st(ST_AUTO);
		rd(ADR_CTRL, 32'h0, 32'h1);
		// tuning that ends in error
		measIn <= measIn - 16'sh0100;
		wr(ADR_CTRL, 32'h1);
		nx(RC + 5);
		tuneFail <= 1'b1;
		nx(1);
		tuneFail <= 1'b0;
		nx(2);
		rd(ADR_STAT, 32'h22, 32'h27);
		wr(ADR_ABSMAN, 32'h0300);
		ov(16'sh00c8);
		wr(ADR_CTRL, 32'h0);
		nx(2);
		st(ST_AUTO);
		// higher status aborts tuning, then manual ends it bumplessly
		measIn <= measIn + 16'sh0100;
		wr(ADR_CTRL, 32'h1);
		nx(3);
		check(tune_running_flag, 32'h1);
		trackReq <= 1'b1;
		nx(2);
		st(ST_TRACK);
		check(tune_running_flag, 32'h0);
		trackReq <= 1'b0;
		wr(ADR_CTRL, 32'h0);
		measIn <= measIn - 16'sh0100;
		wr(ADR_CTRL, 32'h1);
		nx(2);
		wr(ADR_CTRL, 32'h3);
		nx(2);
		st(ST_MAN);
		check(tune_running_flag, 32'h0);
		ov(16'sh00c8);
		// absolute with clamp, differential, ramped up and down
		wr(ADR_CTRL, 32'h2);
		wr(ADR_ABSMAN, 32'h0100);
		ov(16'sh0100);
		wr(ADR_ABSMAN, 32'h0500);
		ov(MAN_MAX);
		wr(ADR_DIFF, 32'h0000ff9c);
		ov(16'sh03b6);
		for (int r = 0; r < 2; r++) begin
			rv(b);
			wr(ADR_CTRL, r ? 32'h32 : 32'h0a);
			nx(40);
			wr(ADR_CTRL, 32'h2);
			rv(n);
			d = r ? b - n : n - b;
			check(r ? (d >= 19 && d <= 24) : (d >= 9 && d <= 12), 32'h1);
		end
		// tuning start from manual holds the manual value while waiting
		measIn <= measIn + 16'sh0100;
		wr(ADR_CTRL, 32'h1);
		nx(3);
		ov(16'(n));
		// stepping type: actuator drive, absolute value refused
		wr(ADR_CTRL, 32'h4a);
		nx(2);
		check(actUp, 32'h1);
		rv(b);
		wr(ADR_ABSMAN, 32'h0010);
		rv(n);
		check(n, b);
		wr(ADR_CTRL, 32'h52);
		nx(2);
		check(actDown, 32'h1);
		check(actUp, 32'h0);
		// switch-off sources with both pin levels
		wr(ADR_FORCE, 32'h5);
		for (int k = 0; k < 8; k++) begin
			switch_off_control_pin <= k[0];
			wr(ADR_CTRL, {23'h0, k[2:1], 7'h0});
			nx(2);
			off = k[2:1] == 2 || (k[2:1] == 1 && k[0]) || (k[2:1] == 3 && !k[0]);
			st(off ? ST_OFF : ST_AUTO);
			check(forcedOut, k[2:1] == 2 ? 3'h5 : 3'h0);
		end
		wr(ADR_CTRL, 32'h0);
		extOffVoltage <= 1'b1;
		nx(2);
		st(ST_OFF);
		ov(16'sh0);
		check(corrOut, 32'h0);
		extOffVoltage <= 1'b0;
		wr(ADR_SETPT, 32'h8300);
		nx(2);
		st(ST_OFF);
		wr(ADR_SETPT, 32'h0150);
		// fail behaviour 6 ignores the fail input
		wr(ADR_SUBST, 32'h0077);
		wr(ADR_CTRL, 32'hc00);
		sensorFail <= 1'b1;
		nx(2);
		st(ST_AUTO);
		check(ctrlMeas, 32'h77);
		sensorFail <= 1'b0;
		// restart from saved manual command
		nvValid <= 1'b1;
		nvCtrl  <= 12'h002;
		rst     <= 1'b1;
		nx(2);
		rst <= 1'b0;
		nx(2);
		st(ST_MAN);
		ov(16'sh0);
		end_sim();
	end
endmodule : test_controller_status_arbiter
